/* pdrf_engine.sv */
// Delayed read forwarding engine for one direction of a PCI-to-PCI bridge.
//
// Summary of operation
// - Every crossing read is queued, never passed; a read that finds all four entries full is retried without an entry.
// - Prefetch reads fetch ahead with all lanes on.
// - Prefetch for line, multiple, prefetchable-space reads.
// - Non-prefetch read fetches one DWORD, own enables.
// - I/O, config, non-prefetchable memory use single DWORD.
// - Prefetch stops at boundary or target disconnect.
// - Final delivered prefetch DWORD carries disconnect.
// - Undelivered prefetch data discarded at initiator end.
// - Flow-through prefetch runs to 4KB boundary.
// - Read and line: 16 DWORD or cache line.
// - Multiple: 32 DWORD or twice cache line.
// - Upstream memory read prefetch is programmable.
// - Capture address, command, parity, then enables; retry.
// - Start only after earlier posted writes drained.
// - Replay exact captured address and command.
// - Drive captured enables, or all low when prefetching.
// - Reissue read after target retry.
// - No further attempts after data then ending.
// - Count failed attempts against limit; flag error.
// - System error output only when enable set.
// - Returned data goes into opposite read queue.
// - Accept one DWORD every clock, no waits.
// - Four entries per direction, no duplicate entries.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module pdrf_engine
    import pdrf_pkg::*;
#(
    parameter int          DEPTH         = 4,
    parameter bit          UPSTREAM      = 1'b0,
    parameter logic [31:0] RETRY_LIMIT   = PDRF_LIMIT_RESET
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_init_addr_valid,
    input  wire pdrf_addr_s  i_init_addr,
    input  wire logic        i_init_irdy,
    input  wire logic [3:0]  i_init_be,
    input  wire logic        i_init_end,
    output logic             o_init_retry,
    input  wire logic        i_posted_empty,
    output pdrf_tcmd_s       o_tgt_cmd,
    input  wire pdrf_tresp_s i_tgt_resp,
    output pdrf_rdq_s        o_rdq,
    output logic             o_rdq_flush,
    output logic             primary_system_error_out
);

    localparam int PTR_W = $clog2(DEPTH);

    initial begin
        if (DEPTH != 4) begin
            $error("DEPTH must be 4 for this queue.");
        end
    end

    typedef struct packed {
        logic [2:0]              ctrl;
        logic [7:0]              cache_line_size;
        logic [31:0]             limit;
        logic                    serr_flag;
        logic                    wait_n;
        logic [31:0]             rdata;
        pdrf_entry_s [DEPTH-1:0] q;
        logic [DEPTH-1:0]        q_vld;
        logic [PTR_W-1:0]        head;
        logic [PTR_W-1:0]        tail;
        logic                    cap_pend;
        pdrf_addr_s              cap;
        logic                    retry;
        pdrf_tstate_e            tstate;
        logic [32:0]             attempts;
        logic [10:0]             remain;
        logic [31:0]             taddr;
        logic                    got_data;
        pdrf_tcmd_s              tcmd;
        pdrf_rdq_s               rdq;
        logic                    flush;
        logic                    serr_out;
    } pdrf_state_s;

    pdrf_state_s state_reg;
    pdrf_state_s state_next;

    function automatic logic is_pow_cls(input logic [7:0] c);
        return (c == 8'h01) || (c == 8'h02) || (c == 8'h04) || (c == 8'h08) || (c == 8'h10);
    endfunction : is_pow_cls

    function automatic logic [10:0] fetch_len(input pdrf_entry_s e, input logic [2:0] ctrl,
                                              input logic [7:0] c);
        logic [10:0] size;
        logic [10:0] offs;
        size = PDRF_ONE_DWORD;
        if (!e.pref) begin
            size = PDRF_ONE_DWORD;
        end else if (ctrl[PDRF_CTRL_FLOW]) begin
            size = PDRF_FLOW_DWORDS;
        end else if (e.cmd == PDRF_CMD_MEM_MULT) begin
            size = is_pow_cls(c) ? {2'h0, c, 1'b0} : PDRF_MULT_DWORDS;
        end else begin
            size = is_pow_cls(c) ? {3'h0, c} : PDRF_LINE_DWORDS;
        end
        offs = e.addr[12:2] & (size - 11'h001);
        return size - offs;
    endfunction : fetch_len

    function automatic logic want_pref(input pdrf_addr_s a, input logic up_pref);
        logic p;
        p = 1'b0;
        if ((a.cmd == PDRF_CMD_MEM_LINE) || (a.cmd == PDRF_CMD_MEM_MULT)) begin
            p = 1'b1;
        end else if (a.cmd == PDRF_CMD_MEM_READ) begin
            p = UPSTREAM ? up_pref : a.pref_space;
        end
        return p;
    endfunction : want_pref

    logic        dup_hit;
    logic        q_full;
    logic [2:0]  q_count;
    logic [32:0] limit_full;
    pdrf_entry_s head_e;

    always_comb begin
        dup_hit = 1'b0;
        q_count = 3'h0;
        for (int k = 0; k < DEPTH; k++) begin
            if (state_reg.q_vld[k] && state_reg.q[k].addr == state_reg.cap.addr
                && state_reg.q[k].cmd == state_reg.cap.cmd) begin
                dup_hit = 1'b1;
            end
            q_count = q_count + {2'h0, state_reg.q_vld[k]};
        end
        q_full     = &state_reg.q_vld;
        head_e     = state_reg.q[state_reg.head];
        limit_full = {state_reg.limit == 32'h0, state_reg.limit};
    end

    always_comb begin
        state_next = state_reg;
        state_next.retry = 1'b0;
        state_next.flush = 1'b0;
        state_next.rdq.valid = 1'b0;
        state_next.rdq.last = 1'b0;
        state_next.wait_n = 1'b0;

        if ((i_avs_read || i_avs_write) && !state_reg.wait_n) begin
            state_next.wait_n = 1'b1;
            state_next.rdata = 32'h0;
            unique case (i_avs_address)
                PDRF_OFS_CTRL:   state_next.rdata = {29'h0, state_reg.ctrl};
                PDRF_OFS_CLS:    state_next.rdata = {24'h0, state_reg.cache_line_size};
                PDRF_OFS_LIMIT:  state_next.rdata = state_reg.limit;
                PDRF_OFS_STATUS: begin
                    state_next.rdata[PDRF_STAT_SERR] = state_reg.serr_flag;
                    state_next.rdata[PDRF_STAT_BUSY] = state_reg.tstate != PDRF_IDLE;
                    state_next.rdata[PDRF_STAT_COUNT +: 3] = q_count;
                end
                default:         state_next.rdata = 32'h0;
            endcase
        end
        if (i_avs_write && state_reg.wait_n) begin
            unique case (i_avs_address)
                PDRF_OFS_CTRL:   state_next.ctrl = i_avs_writedata[2:0];
                PDRF_OFS_CLS:    state_next.cache_line_size = i_avs_writedata[7:0];
                PDRF_OFS_LIMIT:  state_next.limit = i_avs_writedata;
                PDRF_OFS_STATUS: begin
                    if (i_avs_writedata[PDRF_STAT_SERR]) begin
                        state_next.serr_flag = 1'b0;
                    end
                end
                default:         state_next.limit = state_reg.limit;
            endcase
        end

        if (i_init_addr_valid) begin
            state_next.cap_pend = 1'b1;
            state_next.cap = i_init_addr;
        end else if (state_reg.cap_pend && i_init_irdy) begin
            state_next.cap_pend = 1'b0;
            state_next.retry = 1'b1;
            if (!dup_hit && !q_full) begin
                state_next.q_vld[state_reg.tail] = 1'b1;
                state_next.q[state_reg.tail].addr = state_reg.cap.addr;
                state_next.q[state_reg.tail].cmd = state_reg.cap.cmd;
                state_next.q[state_reg.tail].par = state_reg.cap.par;
                state_next.q[state_reg.tail].be = i_init_be;
                state_next.q[state_reg.tail].pref = want_pref(state_reg.cap,
                                                              state_reg.ctrl[PDRF_CTRL_UP_PREF]);
                state_next.tail = state_reg.tail + 1'b1;
            end
        end

        if (i_init_end) begin
            state_next.flush = 1'b1;
        end

        unique case (state_reg.tstate)
            PDRF_IDLE: begin
                if (state_reg.q_vld[state_reg.head] && i_posted_empty) begin
                    state_next.tstate = PDRF_ISSUE;
                    state_next.tcmd.req = 1'b1;
                    state_next.tcmd.addr = head_e.addr;
                    state_next.tcmd.cmd = head_e.cmd;
                    state_next.tcmd.be = head_e.pref ? PDRF_BE_ALL_ON : head_e.be;
                    state_next.remain = fetch_len(head_e, state_reg.ctrl, state_reg.cache_line_size);
                    state_next.tcmd.last = fetch_len(head_e, state_reg.ctrl, state_reg.cache_line_size)
                                           == PDRF_ONE_DWORD;
                    state_next.taddr = head_e.addr;
                    state_next.got_data = 1'b0;
                end
            end
            PDRF_ISSUE, PDRF_DATA: begin
                if (i_tgt_resp.beat) begin
                    state_next.tstate = PDRF_DATA;
                    state_next.got_data = 1'b1;
                    state_next.rdq.valid = 1'b1;
                    state_next.rdq.data = i_tgt_resp.data;
                    state_next.rdq.last = state_reg.tcmd.last || i_tgt_resp.disconnect;
                    state_next.remain = state_reg.remain - 11'h001;
                    state_next.taddr = state_reg.taddr + 32'h4;
                    state_next.tcmd.last = state_reg.remain == 11'h002;
                end
                if (i_tgt_resp.abort || (i_tgt_resp.beat
                    && (state_reg.tcmd.last || i_tgt_resp.disconnect))
                    || (state_reg.got_data && (i_tgt_resp.retry || i_tgt_resp.disconnect))) begin
                    state_next.tstate = PDRF_IDLE;
                    state_next.tcmd.req = 1'b0;
                    state_next.tcmd.last = 1'b0;
                    state_next.q_vld[state_reg.head] = 1'b0;
                    state_next.head = state_reg.head + 1'b1;
                    state_next.attempts = 33'h0;
                end else if (!state_reg.got_data
                             && (i_tgt_resp.retry || i_tgt_resp.disconnect)) begin
                    state_next.attempts = state_reg.attempts + 33'h1;
                    if (state_reg.attempts + 33'h1 == limit_full) begin
                        state_next.serr_flag = 1'b1;
                        state_next.tstate = PDRF_IDLE;
                        state_next.tcmd.req = 1'b0;
                        state_next.q_vld[state_reg.head] = 1'b0;
                        state_next.head = state_reg.head + 1'b1;
                        state_next.attempts = 33'h0;
                    end else begin
                        state_next.tstate = PDRF_ISSUE;
                        state_next.tcmd.addr = head_e.addr;
                    end
                end
            end
            default: state_next.tstate = PDRF_IDLE;
        endcase

        state_next.serr_out = state_next.serr_flag && state_next.ctrl[PDRF_CTRL_SERR_EN];
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '0;
            state_reg.ctrl <= PDRF_CTRL_RESET;
            state_reg.cache_line_size <= PDRF_CLS_RESET;
            state_reg.limit <= RETRY_LIMIT;
            state_reg.tstate <= PDRF_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_avs_readdata = state_reg.rdata;
    assign o_avs_waitrequest = !state_reg.wait_n;
    assign o_init_retry = state_reg.retry;
    assign o_tgt_cmd = state_reg.tcmd;
    assign o_rdq = state_reg.rdq;
    assign o_rdq_flush = state_reg.flush;
    assign primary_system_error_out = state_reg.serr_out;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_req_taken;
        state_reg.cap_pend && i_init_irdy && !i_init_addr_valid;
    endsequence

    sequence s_tgt_start;
        state_reg.tstate == PDRF_IDLE && state_reg.q_vld[state_reg.head] && i_posted_empty;
    endsequence

    a_retry_after_req: assert property (s_req_taken |=> o_init_retry)
        else $error("Captured read was not retried.");
    a_no_dup_entry: assert property ((s_req_taken and dup_hit) |=>
        $stable(state_reg.tail))
        else $error("Duplicate read created an entry.");
    a_start_gated: assert property (o_tgt_cmd.req && !$past(o_tgt_cmd.req)
        |-> $past(i_posted_empty))
        else $error("Target read started before posted writes drained.");
    a_exact_replay: assert property (s_tgt_start |=> o_tgt_cmd.req
        && o_tgt_cmd.addr == $past(head_e.addr) && o_tgt_cmd.cmd == $past(head_e.cmd))
        else $error("Target read differs from captured request.");
    a_pref_be_on: assert property ((s_tgt_start and head_e.pref)
        |=> o_tgt_cmd.be == PDRF_BE_ALL_ON)
        else $error("Prefetch read did not enable all lanes.");
    a_single_dword: assert property ((s_tgt_start and !head_e.pref)
        |=> o_tgt_cmd.last && o_tgt_cmd.be == $past(head_e.be))
        else $error("Single read not limited to one DWORD.");
    a_beat_to_queue: assert property (o_tgt_cmd.req && i_tgt_resp.beat
        |=> o_rdq.valid && o_rdq.data == $past(i_tgt_resp.data))
        else $error("Target DWORD not written to read queue.");
    a_serr_gate: assert property (primary_system_error_out
        |-> state_reg.serr_flag && state_reg.ctrl[PDRF_CTRL_SERR_EN])
        else $error("System error output without enable.");
    a_end_after_data: assert property (o_tgt_cmd.req && state_reg.got_data
        && i_tgt_resp.disconnect |=> !o_tgt_cmd.req ##1 state_reg.tstate != PDRF_DATA)
        else $error("Further attempt after data and disconnect.");
    a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest)
        else $error("Register access not answered in one cycle.");

endmodule : pdrf_engine

/* pdrf_pkg.sv */
// Package with constants and types of the delayed read forwarding engine.
package pdrf_pkg;

    localparam logic [3:0]  PDRF_CMD_IO_READ  = 4'h2;
    localparam logic [3:0]  PDRF_CMD_MEM_READ = 4'h6;
    localparam logic [3:0]  PDRF_CMD_CFG_READ = 4'hA;
    localparam logic [3:0]  PDRF_CMD_MEM_MULT = 4'hC;
    localparam logic [3:0]  PDRF_CMD_MEM_LINE = 4'hE;

    localparam logic [3:0]  PDRF_BE_ALL_ON    = 4'h0;
    localparam logic [10:0] PDRF_FLOW_DWORDS  = 11'h400;
    localparam logic [10:0] PDRF_LINE_DWORDS  = 11'h010;
    localparam logic [10:0] PDRF_MULT_DWORDS  = 11'h020;
    localparam logic [10:0] PDRF_ONE_DWORD    = 11'h001;

    localparam logic [3:0]  PDRF_OFS_CTRL     = 4'h0;
    localparam logic [3:0]  PDRF_OFS_CLS      = 4'h4;
    localparam logic [3:0]  PDRF_OFS_LIMIT    = 4'h8;
    localparam logic [3:0]  PDRF_OFS_STATUS   = 4'hC;

    localparam int          PDRF_CTRL_SERR_EN = 0;
    localparam int          PDRF_CTRL_UP_PREF = 1;
    localparam int          PDRF_CTRL_FLOW    = 2;
    localparam logic [2:0]  PDRF_CTRL_RESET   = 3'h0;
    localparam logic [7:0]  PDRF_CLS_RESET    = 8'h00;
    localparam int          PDRF_STAT_SERR    = 0;
    localparam int          PDRF_STAT_BUSY    = 1;
    localparam int          PDRF_STAT_COUNT   = 4;
    localparam logic [31:0] PDRF_LIMIT_RESET  = 32'h0100_0000;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic        par;
        logic        pref_space;
    } pdrf_addr_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic        par;
        logic [3:0]  be;
        logic        pref;
    } pdrf_entry_s;

    typedef struct packed {
        logic        beat;
        logic        retry;
        logic        disconnect;
        logic        abort;
        logic [31:0] data;
    } pdrf_tresp_s;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic [3:0]  be;
        logic        last;
    } pdrf_tcmd_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
    } pdrf_rdq_s;

    typedef enum logic [1:0] {PDRF_IDLE, PDRF_ISSUE, PDRF_DATA} pdrf_tstate_e;

endpackage : pdrf_pkg

/* pdrf_tgt_model.sv */
// Behavioural PCI target that answers the engine's read attempts.
`timescale 1ns/1ps
module pdrf_tgt_model
    import pdrf_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire pdrf_tcmd_s  i_cmd,
    input  wire logic [7:0]  i_retries,
    input  wire logic [7:0]  i_disc_at,
    output pdrf_tresp_s      o_resp
);
    logic [7:0]  rcnt;
    logic [10:0] bcnt;
    pdrf_tresp_s resp_reg;
    // A released data bus shows the inverse of its last value.
    assign o_resp = i_cmd.req ? resp_reg : pdrf_tresp_s'({4'h0, resp_reg.data});
    always_ff @(posedge i_clk) begin
        resp_reg.beat       <= 1'b0;
        resp_reg.retry      <= 1'b0;
        resp_reg.disconnect <= 1'b0;
        resp_reg.abort      <= 1'b0;
        resp_reg.data       <= ~resp_reg.data;
        if (i_reset) begin
            rcnt          <= 8'h00;
            bcnt          <= 11'h000;
            resp_reg.data <= 32'h5555_5555;
        end else if (i_cmd.req !== 1'b1) begin
            rcnt <= 8'h00;
            bcnt <= 11'h000;
        end else if (rcnt < i_retries) begin
            resp_reg.retry <= 1'b1;
            rcnt           <= rcnt + 8'h01;
        end else begin
            resp_reg.beat       <= 1'b1;
            resp_reg.disconnect <= ({3'h0, i_disc_at} == bcnt + 11'h001);
            resp_reg.data       <= i_cmd.addr + {19'h00000, bcnt, 2'b00};
            bcnt                <= bcnt + 11'h001;
        end
    end
endmodule : pdrf_tgt_model

/* tb_pci_delayed_read_forwarding.sv */
// Self-checking bench for the delayed read forwarding engine.
`timescale 1ns/1ps
module tb_pci_delayed_read_forwarding
    import pdrf_pkg::*;
;
    localparam logic [31:0] LIM = 32'h0000_0004;
    logic        i_clk;
    logic        i_reset;
    logic [3:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wd;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        iv;
    pdrf_addr_s  ia;
    logic        irdy;
    logic [3:0]  ibe;
    logic        iend;
    logic        iretry;
    logic        posted;
    pdrf_tcmd_s  tcmd;
    pdrf_tresp_s tresp;
    pdrf_rdq_s   rdq;
    logic        flush;
    logic        serr;
    logic [7:0]  retries;
    logic [7:0]  disc;
    int          error_cnt = 0;
    int          tests_run = 0;

    pdrf_engine #(.DEPTH(4), .UPSTREAM(1'b0), .RETRY_LIMIT(LIM)) pdrf_engine_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait), .i_init_addr_valid(iv), .i_init_addr(ia),
        .i_init_irdy(irdy), .i_init_be(ibe), .i_init_end(iend), .o_init_retry(iretry),
        .i_posted_empty(posted), .o_tgt_cmd(tcmd), .i_tgt_resp(tresp), .o_rdq(rdq),
        .o_rdq_flush(flush), .primary_system_error_out(serr));

    pdrf_tgt_model pdrf_tgt_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_cmd(tcmd),
        .i_retries(retries), .i_disc_at(disc), .o_resp(tresp));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic test_done;
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t %s got %h expected %h", $time, m, g, e);
        end
    endtask : chk

    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        @(posedge i_clk);
        av_addr <= a;
        av_wr   <= w;
        av_rd   <= !w;
        av_wd   <= d;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (av_wait !== 1'b0);
        r = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        chk(n, 2, "bus answer");
    endtask : avs

    task automatic ireq(input logic [3:0] c, input logic [31:0] a, input logic pf,
                        input logic [3:0] be);
        @(posedge i_clk);
        iv <= 1'b1;
        ia <= '{addr: a, cmd: c, par: ^{a, c}, pref_space: pf};
        @(posedge i_clk);
        iv   <= 1'b0;
        irdy <= 1'b1;
        ibe  <= be;
        @(posedge i_clk);
        irdy <= 1'b0;
        @(negedge i_clk);
        chk(iretry, 1'b1, "initiator retry");
    endtask : ireq

    task automatic fetch(input logic [31:0] a, input logic [3:0] c, input logic [3:0] be,
                         input int n, input bit q);
        int k;
        int t;
        k = 0;
        t = 0;
        while (tcmd.req !== 1'b1 && t < 2000) begin
            @(negedge i_clk);
            t++;
        end
        chk(tcmd.addr, a, "target address");
        chk(tcmd.cmd, c, "target command");
        chk(tcmd.be, be, "target enables");
        while (k < n && t < 4000) begin
            @(negedge i_clk);
            t++;
            if (rdq.valid === 1'b1) begin
                chk(rdq.data, a + 32'(4 * k), "queue data");
                chk(rdq.last, k == n - 1, "final flag");
                k++;
            end else if (k > 0) chk(1'b0, 1'b1, "beat gap");
        end
        chk(k, n, "beat count");
        if (q) begin
            repeat (4) @(negedge i_clk);
            chk({tcmd.req, rdq.valid}, 2'b00, "no more attempts");
        end
    endtask : fetch

    task automatic t_regs;
        logic [31:0] r;
        avs(1'b0, PDRF_OFS_CTRL, 32'h0, r);
        chk(r, {29'h0, PDRF_CTRL_RESET}, "ctrl reset");
        avs(1'b0, PDRF_OFS_CLS, 32'h0, r);
        chk(r, {24'h0, PDRF_CLS_RESET}, "cls reset");
        avs(1'b0, PDRF_OFS_LIMIT, 32'h0, r);
        chk(r, LIM, "limit reset");
        avs(1'b1, PDRF_OFS_LIMIT, 32'h0000_0007, r);
        avs(1'b0, PDRF_OFS_LIMIT, 32'h0, r);
        chk(r, 32'h0000_0007, "limit write");
        avs(1'b1, PDRF_OFS_LIMIT, LIM, r);
        avs(1'b0, PDRF_OFS_STATUS, 32'h0, r);
        chk(r, 32'h0, "status reset");
        avs(1'b1, 4'h2, 32'hFFFF_FFFF, r);
        avs(1'b0, 4'h2, 32'h0, r);
        chk(r, 32'h0, "unmapped");
    endtask : t_regs

    task automatic t_single;
        logic [3:0] c [3] = '{PDRF_CMD_IO_READ, PDRF_CMD_CFG_READ, PDRF_CMD_MEM_READ};
        logic [31:0] r;
        avs(1'b1, PDRF_OFS_CTRL, 32'h2, r);
        for (int i = 0; i < 3; i++) begin
            @(posedge i_clk);
            posted <= 1'b0;
            ireq(c[i], 32'h0000_0104 + 32'(16 * i), 1'b0, 4'h5);
            repeat (6) @(negedge i_clk);
            chk(tcmd.req, 1'b0, "held by posted writes");
            @(posedge i_clk);
            posted <= 1'b1;
            fetch(32'h0000_0104 + 32'(16 * i), c[i], 4'h5, 1, 1'b1);
        end
    endtask : t_single

    task automatic t_prefetch;
        logic [31:0] r;
        logic [3:0]  c [6] = '{PDRF_CMD_MEM_LINE, PDRF_CMD_MEM_LINE, PDRF_CMD_MEM_READ,
                               PDRF_CMD_MEM_MULT, PDRF_CMD_MEM_MULT, PDRF_CMD_MEM_LINE};
        logic [7:0]  s [6] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h04, 8'h10};
        logic [31:0] a [6] = '{32'h0000_6000, 32'h0000_1000, 32'h0000_2000,
                               32'h0000_3000, 32'h0000_4000, 32'h0000_5030};
        int          n [6] = '{1024, 16, 8, 32, 8, 4};
        for (int i = 0; i < 6; i++) begin
            avs(1'b1, PDRF_OFS_CLS, {24'h0, s[i]}, r);
            avs(1'b1, PDRF_OFS_CTRL, (i == 0) ? 32'h4 : 32'h0, r);
            ireq(c[i], a[i], 1'b1, 4'h3);
            fetch(a[i], c[i], PDRF_BE_ALL_ON, n[i], 1'b1);
        end
    endtask : t_prefetch

    task automatic t_retry;
        logic [31:0] r;
        @(posedge i_clk);
        disc    <= 8'h03;
        retries <= 8'h02;
        ireq(PDRF_CMD_MEM_MULT, 32'h0000_7000, 1'b0, 4'h0);
        fetch(32'h0000_7000, PDRF_CMD_MEM_MULT, PDRF_BE_ALL_ON, 3, 1'b1);
        avs(1'b0, PDRF_OFS_STATUS, 32'h0, r);
        chk(r[PDRF_STAT_SERR], 1'b0, "no early error");
        disc <= 8'h00;
    endtask : t_retry

    task automatic t_limit;
        logic [31:0] r;
        int t;
        t = 0;
        r = 32'h0;
        @(posedge i_clk);
        retries <= 8'hFF;
        ireq(PDRF_CMD_IO_READ, 32'h0000_0300, 1'b0, 4'h0);
        while (r[PDRF_STAT_SERR] !== 1'b1 && t < 60) begin
            avs(1'b0, PDRF_OFS_STATUS, 32'h0, r);
            t++;
        end
        chk(r[PDRF_STAT_SERR], 1'b1, "limit error");
        chk(serr, 1'b0, "masked system error");
        avs(1'b1, PDRF_OFS_CTRL, 32'h1, r);
        avs(1'b0, PDRF_OFS_CTRL, 32'h0, r);
        chk(serr, 1'b1, "system error");
        avs(1'b1, PDRF_OFS_STATUS, 32'h1, r);
        avs(1'b0, PDRF_OFS_STATUS, 32'h0, r);
        chk(serr, 1'b0, "error cleared");
        retries <= 8'h00;
    endtask : t_limit

    task automatic t_queue;
        logic [31:0] r;
        @(posedge i_clk);
        posted <= 1'b0;
        ireq(PDRF_CMD_MEM_READ, 32'h0000_0400, 1'b0, 4'h1);
        ireq(PDRF_CMD_MEM_READ, 32'h0000_0400, 1'b0, 4'h1);
        avs(1'b0, PDRF_OFS_STATUS, 32'h0, r);
        chk(r[6:4], 3'h1, "duplicate entry");
        for (int i = 1; i < 5; i++) begin
            ireq(PDRF_CMD_MEM_READ, 32'h0000_0400 + 32'(16 * i), 1'b0, 4'h1);
        end
        avs(1'b0, PDRF_OFS_STATUS, 32'h0, r);
        chk(r[6:4], 3'h4, "queue full");
        @(posedge i_clk);
        posted <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            fetch(32'h0000_0400 + 32'(16 * i), PDRF_CMD_MEM_READ, 4'h1, 1, i == 3);
        end
        @(posedge i_clk);
        iend <= 1'b1;
        @(posedge i_clk);
        iend <= 1'b0;
        @(negedge i_clk);
        chk(flush, 1'b1, "discard");
    endtask : t_queue

    initial begin
        {av_addr, av_rd, av_wr, av_wd, iv, ia, irdy, ibe, iend, posted} = '0;
        {retries, disc} = '0;
        i_reset = 1'b1;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_single();
        t_prefetch();
        t_retry();
        t_limit();
        t_queue();
        test_done();
    end

    initial begin
        repeat (30000) @(posedge i_clk);
        error_cnt++;
        test_done();
    end
endmodule : tb_pci_delayed_read_forwarding
